// ---- verif/nvm_array_model.sv ----
// behavioural model of the nonvolatile arrays
`timescale 1ns/1ps
`include "nvm_map.vh"
module nvm_array_model (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // array side
    input wire nvm_start,
    input wire [2:0] nvm_op,
    output reg nvm_done,
    output reg nvm_abort,
    // bench controls
    input wire slow,
    input wire abort_req
);
    reg busy_q;
    reg [5:0] cnt_q;
    always @(posedge aclk) begin
        nvm_done <= 1'b0;
        nvm_abort <= 1'b0;
        if (!aresetn) begin
            busy_q <= 1'b0;
        end else if (nvm_start && nvm_op != `OP_READ) begin
            busy_q <= 1'b1;
            cnt_q <= slow ? 6'h28 : 6'h03;
        end else if (busy_q && abort_req) begin
            busy_q <= 1'b0;
            nvm_abort <= 1'b1;
        end else if (busy_q && cnt_q == 6'h00) begin
            busy_q <= 1'b0;
            nvm_done <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 6'h01;
        end
    end
endmodule // nvm_array_model

// ---- verif/nvm_chk.sv ----
// bus and array-side timing checker of the nvm control block
`timescale 1ns/1ps
`include "nvm_map.vh"
module nvm_chk (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire bvalid,
    input wire bready,
    input wire [1:0] bresp,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire rready,
    input wire [31:0] rdata,
    // array side
    input wire nvm_start,
    input wire [2:0] nvm_op,
    input wire [1:0] nvm_space
);
    // --------------------------------
    // assertions
    // --------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_START_PULSE: assert property (nvm_start |=> !nvm_start)
        else $error("start pulse too long");
    AST_START_WITH_B: assert property (nvm_start |-> bvalid && !$past(bvalid))
        else $error("start not tied to write response");
    AST_OP_LEGAL: assert property (nvm_start |-> nvm_op != `OP_NONE && nvm_op <= `OP_EE_ERASE_WRITE
        && nvm_space != 2'h3)
        else $error("illegal op or space");
    AST_EE_OP: assert property (nvm_start && nvm_space == `SPACE_EEPROM && nvm_op != `OP_READ
        |-> nvm_op == `OP_EE_ERASE_WRITE)
        else $error("eeprom op not erase and write");
    AST_FLASH_OP: assert property (nvm_start && nvm_space != `SPACE_EEPROM
        |-> nvm_op != `OP_EE_ERASE_WRITE)
        else $error("eeprom op on flash space");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid
        && !nvm_start)
        else $error("outputs not cleared by reset");
    AST_B_AFTER_W: assert property (awvalid && awready && wvalid && wready |=> bvalid)
        else $error("write response late");
    AST_R_AFTER_AR: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read response late");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
endmodule // nvm_chk

bind nvm_control_register_logic nvm_chk nvm_chk_i (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
    .nvm_start, .nvm_op, .nvm_space);

// ---- verif/nvm_control_register_logic_tb_top.sv ----
// self-checking bench of the nvm control block
`timescale 1ns/1ps
`include "nvm_map.vh"
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
    mismatches = mismatches + 1; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module nvm_control_register_logic_tb_top;
    reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, abort_req;
    reg [7:0] awaddr;
    reg [7:0] araddr;
    reg [31:0] wdata;
    reg [3:0] wstrb;
    wire awready, wready, bvalid, arready, rvalid, nvm_start, nvm_done, nvm_abort;
    wire [1:0] bresp;
    wire [1:0] rresp;
    wire [1:0] nvm_space;
    wire [31:0] rdata;
    wire [2:0] nvm_op;
    integer mismatches = 0;
    integer n_compared = 0;
    integer n_starts = 0;
    integer k;
    reg [2:0] last_op;
    reg [1:0] last_sp;
    reg [7:0] d;
    reg [1:0] r;
    nvm_control_register_logic nvm_control_register_logic_i (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .nvm_start, .nvm_op, .nvm_space, .nvm_done, .nvm_abort);
    nvm_array_model nvm_array_model_i (.aclk, .aresetn, .nvm_start, .nvm_op, .nvm_done,
        .nvm_abort, .slow, .abort_req);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (nvm_start === 1'b1) begin
            n_starts = n_starts + 1;
            last_op = nvm_op;
            last_sp = nvm_space;
        end
    end
    task end_sim;
        begin
            if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task rst;
        begin
            aresetn <= 1'b0;
            repeat (12) @(posedge aclk);
            aresetn <= 1'b1;
            @(posedge aclk);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v, input [3:0] s);
        integer n;
        begin
            @(posedge aclk);
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            awaddr <= a;
            wdata <= {24'h000000, v};
            wstrb <= s;
            bready <= 1'b1;
            n = 0;
            r = 2'h3;
            while (r === 2'h3) begin
                @(posedge aclk);
                n = n + 1;
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid && bready) begin
                    r = bresp;
                    bready <= 1'b0;
                end
                if (n > 40) begin
                    mismatches = mismatches + 1;
                    end_sim;
                end
            end
        end
    endtask
    task rd(input [7:0] a);
        integer n;
        begin
            @(posedge aclk);
            arvalid <= 1'b1;
            araddr <= a;
            rready <= 1'b1;
            n = 0;
            r = 2'h3;
            while (r === 2'h3) begin
                @(posedge aclk);
                n = n + 1;
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid && rready) begin
                    r = rresp;
                    d = rdata[7:0];
                    rready <= 1'b0;
                end
                if (n > 40) begin
                    mismatches = mismatches + 1;
                    end_sim;
                end
            end
        end
    endtask
    task wait_idle;
        integer n;
        begin
            n = 0;
            d = 8'h02;
            while (d[1] !== 1'b0 && n < 60) begin
                rd(`NVM_CONTROL_OFS);
                n = n + 1;
            end
            if (d[1] !== 1'b0) begin
                mismatches = mismatches + 1;
                end_sim;
            end
        end
    endtask
    task s_reset;
        begin
            rd(`NVM_CONTROL_OFS);
            `CHK(d, `NVM_CONTROL_RESET)
            rd(`NVM_STATUS_OFS);
            `CHK({r, d}, {`RESP_OKAY, 8'h20})
            rd(8'h08);
            `CHK({r, d}, {`RESP_SLVERR, 8'h00})
            wr(8'h08, 8'hFF, 4'hF);
            `CHK(r, `RESP_SLVERR)
            wr(`NVM_CONTROL_OFS, 8'h84, 4'h0);
            `CHK(r, `RESP_OKAY)
            rd(`NVM_CONTROL_OFS);
            `CHK(d, 8'h00)
        end
    endtask
    task s_no_enable;
        begin
            k = n_starts;
            wr(`NVM_CONTROL_OFS, 8'h80, 4'hF);
            wr(`NVM_CONTROL_OFS, 8'h82, 4'hF);
            rd(`NVM_CONTROL_OFS);
            `CHK(d, 8'h88)
            `CHK(n_starts, k)
        end
    endtask
    task op_case(input [7:0] c, input [2:0] op, input [1:0] sp);
        begin
            k = n_starts;
            wr(`NVM_CONTROL_OFS, c, 4'hF);
            wr(`NVM_CONTROL_OFS, c | 8'h02, 4'hF);
            wait_idle;
            `CHK(n_starts, k + 1)
            `CHK({last_sp, last_op}, {sp, op})
            `CHK(d, (op == `OP_ERASE) ? (c & 8'hEF) : c)
        end
    endtask
    task s_read;
        begin
            k = n_starts;
            wr(`NVM_CONTROL_OFS, 8'h81, 4'hF);
            rd(`NVM_CONTROL_OFS);
            `CHK(d, 8'h80)
            `CHK(last_op, `OP_READ)
            wr(`NVM_CONTROL_OFS, 8'h80, 4'hF);
            repeat (2) @(posedge aclk);
            `CHK(n_starts, k + 1)
        end
    endtask
    task s_busy;
        begin
            @(posedge aclk) slow <= 1'b1;
            wr(`NVM_CONTROL_OFS, 8'h84, 4'hF);
            wr(`NVM_CONTROL_OFS, 8'h86, 4'hF);
            @(posedge aclk);
            k = n_starts;
            wr(`NVM_CONTROL_OFS, 8'h84, 4'hF);
            wr(`NVM_CONTROL_OFS, 8'h86, 4'hF);
            rd(`NVM_CONTROL_OFS);
            `CHK(d, 8'h86)
            `CHK(n_starts, k)
            @(posedge aclk) abort_req <= 1'b1;
            wait_idle;
            @(posedge aclk) abort_req <= 1'b0;
            `CHK(d, 8'h8C)
        end
    endtask
    task s_cut;
        begin
            wr(`NVM_CONTROL_OFS, 8'h86, 4'hF);
            rst;
            rd(`NVM_CONTROL_OFS);
            `CHK(d, 8'h08)
        end
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, slow, abort_req} = 8'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        rst;
        s_reset;
        s_no_enable;
        op_case(8'h84, `OP_LATCH_WRITE, `SPACE_FLASH);
        op_case(8'hA4, `OP_LATCH_ONLY, `SPACE_FLASH);
        op_case(8'h94, `OP_ERASE, `SPACE_FLASH);
        op_case(8'h44, `OP_LATCH_WRITE, `SPACE_CONFIG);
        op_case(8'h54, `OP_ERASE, `SPACE_CONFIG);
        op_case(8'h34, `OP_EE_ERASE_WRITE, `SPACE_EEPROM);
        s_read;
        s_busy;
        s_cut;
        end_sim;
    end
endmodule // nvm_control_register_logic_tb_top

// ---- verilog/nvm_control_register_logic.v ----
// nvm control register logic with axi4-lite register slave
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "nvm_map.vh"

// Functional notes
// - Bit 7 steers the next operation to program flash when 1 and to data eeprom when 0; bit 6 set overrides it and selects config.
// - For config or flash with latch-only set and erase-select clear, a write trigger only loads the latches.
// - For config or flash with latch-only and erase-select clear, a write trigger loads and writes the latches.
// - For data eeprom the latch-only bit is ignored and the trigger writes eeprom directly.
// - For config or flash, erase-select makes the trigger an erase and is cleared when it completes without abort.
// - For data eeprom the erase-select bit is ignored and each trigger erases then writes.
// - The error flag is set on an improper or aborted sequence and stays 0 on normal completion.
// - Program and erase start only when the enable bit is 1; a trigger while it is 0 is inhibited.
// - Setting the write trigger starts a program or erase on the selected space.
// - Hardware clears the write trigger on completion, so 0 means nothing is in progress.
// - Writing 0 to the write trigger does nothing; software can only set it.
// - Reset clears all control bits; the error flag records an operation cut by reset.
module nvm_control_register_logic (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire awvalid,
    output reg awready,
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    // axi4-lite write data
    input wire wvalid,
    output reg wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // axi4-lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // axi4-lite read address
    input wire arvalid,
    output reg arready,
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    // axi4-lite read data
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // nonvolatile array side
    output reg nvm_start,
    output reg [2:0] nvm_op,
    output reg [1:0] nvm_space,
    input wire nvm_done,
    input wire nvm_abort
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function is_control;
        input [7:0] addr;
        begin
            is_control = (addr == `NVM_CONTROL_OFS);
        end
    endfunction

    function is_status;
        input [7:0] addr;
        begin
            is_status = (addr == `NVM_STATUS_OFS);
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg flash_sel_q;
    reg cfg_sel_q;
    reg latch_only_q;
    reg erase_sel_q;
    reg err_q;
    reg enable_q;
    reg wr_trig_q;
    reg rd_trig_q;
    reg rst_seen_q;
    reg aw_have_q;
    reg w_have_q;
    reg [7:0] waddr_q;
    reg [31:0] wdat_q;
    reg [3:0] wstb_q;
    reg [2:0] op_q;
    reg [2:0] op_d;
    reg [1:0] space_d;
    reg [7:0] ctrl_rd;

    wire aw_hs;
    wire w_hs;
    wire ar_hs;
    wire aw_have_d;
    wire w_have_d;
    wire [7:0] waddr_d;
    wire [31:0] wdat_d;
    wire [3:0] wstb_d;
    wire do_wr;
    wire bvalid_d;
    wire rvalid_d;
    wire sw_ctrl;
    wire wr_attempt;
    wire rd_attempt;
    wire start_wr;
    wire start_rd;
    wire bad_wr;
    wire op_end;

    // ----------------------------------------
    // write channel capture
    // ----------------------------------------
    assign aw_hs = awvalid & awready;
    assign w_hs = wvalid & wready;
    assign ar_hs = arvalid & arready;
    assign aw_have_d = aw_have_q | aw_hs;
    assign w_have_d = w_have_q | w_hs;
    assign waddr_d = aw_hs ? awaddr : waddr_q;
    assign wdat_d = w_hs ? wdata : wdat_q;
    assign wstb_d = w_hs ? wstrb : wstb_q;
    assign do_wr = aw_have_d & w_have_d & ~bvalid;
    assign bvalid_d = do_wr | (bvalid & ~bready);
    assign rvalid_d = ar_hs | (rvalid & ~rready);

    // ----------------------------------------
    // trigger decode
    // ----------------------------------------
    assign sw_ctrl = do_wr & is_control(waddr_d) & wstb_d[0];
    assign wr_attempt = sw_ctrl & wdat_d[`WRITE_TRIGGER_BIT];
    assign rd_attempt = sw_ctrl & wdat_d[`READ_TRIGGER_BIT];
    assign start_wr = wr_attempt & enable_q & (state_q == ST_IDLE);
    assign bad_wr = wr_attempt & ~enable_q & (state_q == ST_IDLE);
    assign start_rd = rd_attempt & ~wr_attempt & (state_q == ST_IDLE);
    assign op_end = (state_q == ST_RUN) & (nvm_done | nvm_abort);

    // ----------------------------------------
    // operation and space select
    // ----------------------------------------
    always @* begin
        op_d = `OP_NONE;
        if (cfg_sel_q) begin
            space_d = `SPACE_CONFIG;
        end else if (flash_sel_q) begin
            space_d = `SPACE_FLASH;
        end else begin
            space_d = `SPACE_EEPROM;
        end
        if (start_rd) begin
            op_d = `OP_READ;
        end else if (space_d == `SPACE_EEPROM) begin
            op_d = `OP_EE_ERASE_WRITE;
        end else if (erase_sel_q) begin
            op_d = `OP_ERASE;
        end else if (latch_only_q) begin
            op_d = `OP_LATCH_ONLY;
        end else begin
            op_d = `OP_LATCH_WRITE;
        end
    end

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_wr) begin
                    state_d = ST_RUN;
                end else if (start_rd) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                state_d = ST_IDLE;
            end
            ST_RUN: begin
                if (op_end) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            // control bits cleared, error keeps a cut write
            state_q <= ST_IDLE;
            flash_sel_q <= 1'b0;
            cfg_sel_q <= 1'b0;
            latch_only_q <= 1'b0;
            erase_sel_q <= 1'b0;
            enable_q <= 1'b0;
            wr_trig_q <= 1'b0;
            rd_trig_q <= 1'b0;
            rst_seen_q <= 1'b1;
            if (wr_trig_q) begin
                err_q <= 1'b1;
            end else if (rst_seen_q) begin
                err_q <= err_q;
            end else begin
                err_q <= 1'b0;
            end
            op_q <= `OP_NONE;
        end else begin
            state_q <= state_d;
            rst_seen_q <= 1'b0;
            if (sw_ctrl) begin
                flash_sel_q <= wdat_d[`FLASH_SPACE_SELECT_BIT];
                cfg_sel_q <= wdat_d[`CONFIG_SPACE_SELECT_BIT];
                latch_only_q <= wdat_d[`LATCH_LOAD_ONLY_BIT];
                enable_q <= wdat_d[`PROGRAM_ERASE_ENABLE_BIT];
            end
            // erase bit cleared when an erase ends with nvm_done, kept on abort
            if (op_end & nvm_done & (op_q == `OP_ERASE)) begin
                erase_sel_q <= 1'b0;
            end else if (sw_ctrl) begin
                erase_sel_q <= wdat_d[`ERASE_SELECT_BIT];
            end
            // hardware set wins over software clear
            if (bad_wr | (op_end & nvm_abort)) begin
                err_q <= 1'b1;
            end else if (sw_ctrl) begin
                err_q <= wdat_d[`SEQUENCE_ERROR_FLAG_BIT];
            end
            if (start_wr) begin
                wr_trig_q <= 1'b1;
            end else if (op_end) begin
                wr_trig_q <= 1'b0;
            end
            rd_trig_q <= start_rd;
            if (start_wr | start_rd) begin
                op_q <= op_d;
            end
        end
    end

    // ----------------------------------------
    // array outputs
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            nvm_start <= 1'b0;
            nvm_op <= `OP_NONE;
            nvm_space <= `SPACE_EEPROM;
        end else begin
            nvm_start <= start_wr | start_rd;
            if (start_wr | start_rd) begin
                nvm_op <= op_d;
                nvm_space <= space_d;
            end
        end
    end

    // ----------------------------------------
    // register read view
    // ----------------------------------------
    always @* begin
        ctrl_rd = {flash_sel_q, cfg_sel_q, latch_only_q, erase_sel_q,
                   err_q, enable_q, wr_trig_q, rd_trig_q};
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= 8'h00;
            wdat_q <= 32'h00000000;
            wstb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d & ~do_wr;
            w_have_q <= w_have_d & ~do_wr;
            waddr_q <= waddr_d;
            wdat_q <= wdat_d;
            wstb_q <= wstb_d;
            awready <= ~(aw_have_d & ~do_wr) & ~bvalid_d;
            wready <= ~(w_have_d & ~do_wr) & ~bvalid_d;
            bvalid <= bvalid_d;
            if (do_wr) begin
                if (is_control(waddr_d) | is_status(waddr_d)) begin
                    bresp <= `RESP_OKAY;
                end else begin
                    bresp <= `RESP_SLVERR;
                end
            end
            arready <= ~rvalid_d;
            rvalid <= rvalid_d;
            if (ar_hs) begin
                if (is_control(araddr)) begin
                    rdata <= {24'h000000, ctrl_rd};
                    rresp <= `RESP_OKAY;
                end else if (is_status(araddr)) begin
                    rdata <= {24'h000000, state_q, op_q, space_d};
                    rresp <= `RESP_OKAY;
                end else begin
                    rdata <= 32'h00000000;
                    rresp <= `RESP_SLVERR;
                end
            end
        end
    end

endmodule // nvm_control_register_logic

// ---- verilog/nvm_map.vh ----
// register map, field positions and codes of the nvm control block
`ifndef NVM_MAP_VH
`define NVM_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define NVM_CONTROL_OFS 8'h00
`define NVM_STATUS_OFS 8'h04

// ----------------------------------------
// nvm_control field positions
// ----------------------------------------
`define FLASH_SPACE_SELECT_BIT 7
`define CONFIG_SPACE_SELECT_BIT 6
`define LATCH_LOAD_ONLY_BIT 5
`define ERASE_SELECT_BIT 4
`define SEQUENCE_ERROR_FLAG_BIT 3
`define PROGRAM_ERASE_ENABLE_BIT 2
`define WRITE_TRIGGER_BIT 1
`define READ_TRIGGER_BIT 0
`define NVM_CONTROL_RESET 8'h00

// ----------------------------------------
// array operation codes
// ----------------------------------------
`define OP_NONE 3'h0
`define OP_READ 3'h1
`define OP_LATCH_ONLY 3'h2
`define OP_LATCH_WRITE 3'h3
`define OP_ERASE 3'h4
`define OP_EE_ERASE_WRITE 3'h5

// ----------------------------------------
// target space codes
// ----------------------------------------
`define SPACE_EEPROM 2'h0
`define SPACE_FLASH 2'h1
`define SPACE_CONFIG 2'h2

// ----------------------------------------
// bus response codes
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
